// file: wsp_map.svh
// Purpose: Offsets, field positions, codes and timing counts of the player
// Assumes: 250 MHz system clock
// Notes: Included by both link ends
`ifndef WSP_MAP_SVH
`define WSP_MAP_SVH
`define WSP_CLK_MHZ 250
`define WSP_ROUTE_IDLE_NS 4000
`define WSP_ROUTE_IDLE_CYC ((`WSP_ROUTE_IDLE_NS * `WSP_CLK_MHZ) / 1000)
`define WSP_WORD_LAST 4'hF
`define WSP_SEQ_LAST 4'hE
`define WSP_MODE_RAM_SYNTH 2'h3
`define WSP_BC_STATUS 5'h0C
`define WSP_CMD_SYNTH_WR 16'h0001
`define WSP_CMD_SEQ 16'h0002
`define WSP_CMD_BURST_WR 16'h0004
`define WSP_CMD_RANGE 16'h0012
`define WSP_SYNTH_LAST 4'h2
`define WSP_REG_OUTPUT 4'h5
`define WSP_REG_RAM 4'h8
`define WSP_REG_BCAST 4'h9
`define WSP_OE_BIT 4
`define WSP_ROUTE_BIT 2
`define WSP_BC_HI 11
`define WSP_BC_LO 7
`define WSP_ST_EMPTY 0
`define WSP_ST_PLAY 1
`define WSP_ST_ROUTE 2
`define WSP_APB_TX 12'h000
`define WSP_APB_RX 12'h004
`define WSP_APB_STAT 12'h008
`endif

// file: wsp_pkg.sv
// Purpose: Shared types of the waveform sequence player
// Assumes: Nothing
// Notes: Numbers live in wsp_map.svh
package wsp_pkg;
  typedef logic [9:0] wsp_addr_t;
  typedef logic [15:0] wsp_word_t;
  typedef enum logic [2:0] {I_CMD, I_ADDR, I_DATA, I_SEQ, I_RANGE} wsp_ist_t;
  typedef enum logic [1:0] {P_IDLE, P_FETCH, P_RUN} wsp_pst_t;
  typedef enum logic [1:0] {H_IDLE, H_XFER, H_END} wsp_hst_t;
endpackage

// file: wsp_link_if.sv
// Purpose: Four-wire serial link between host and player
// Assumes: Host is the only master
// Notes: Mode 0, sixteen bits a word, MSB first
`timescale 1ns/100ps
`default_nettype none
interface wsp_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

// file: wsp_dev.sv
// Purpose: Player end: register map, command interpreter, table and playback
// Assumes: Link pins come from another clock domain
// Notes: Slice synthesis is reduced to stepping slice word addresses
// Function
// - Fifteen-entry sequence table, entries 0 to 14
// - Host loads all fifteen entries in order
// - Entries outside play range are don't care
// - Entry bits 9:0 address, 15:10 ignored
// - Play start to end ascending, then stop
// - Widest range is entry 0 to 14
// - Start equal end plays one entry
// - Mode value 3 selects RAM synthesis
// - Route bit sends words to interpreter
// - Word 0x8007 selects synthesis and routes
// - Host keeps commands under 4 us apart
// - Idle over 4 us returns to registers
// - Synthesis write and burst write fill RAM
// - Command 0x0001, address, then consecutive data
// - Broadcast select 0xC shifts status on SDO
// - Output enable starts, clearing it stops
// - Empty flag set when waveform completes
// - Host may configure sensing before status select
// - Wave block: first slice, last slice, count
// - Repeat count times, zero means once
//
// Local design decisions: register access over APB and the register addresses.
`include "wsp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module wsp_dev #(
  parameter int PLAY_TICK_CYCLES = 8
) (
  input wire logic CLK,
  input wire logic RESET,
  wsp_link_if.dev LINK,
  output logic PLAY_ACTIVE,
  output wsp_pkg::wsp_addr_t PLAY_SLICE_ADDR,
  output logic PLAY_EMPTY
);
  import wsp_pkg::*;

  function automatic logic [3:0] clamp_entry(input logic [3:0] v);
    return (v > `WSP_SEQ_LAST) ? `WSP_SEQ_LAST : v;
  endfunction

  logic [1:0] sclk_s, cs_s, mosi_s;
  logic sclk_prev_q, cs_prev_q;
  wsp_word_t shift_q, tx_q;
  logic [3:0] bit_q;
  logic [10:0] idle_q;
  logic route_q, oe_q, oe_prev_q;
  logic [1:0] mode_q;
  logic [4:0] bc_q;
  wsp_ist_t ist_q;
  logic [3:0] icnt_q;
  logic burst_q;
  wsp_addr_t wptr_q;
  wsp_word_t ram [1024];
  wsp_addr_t seq_q [15];
  logic [3:0] start_q, end_q, idx_q;
  wsp_pst_t pst_q;
  wsp_addr_t sl_start_q, sl_end_q, pa_q;
  logic [15:0] rep_q;
  logic [15:0] tdiv_q;
  logic empty_q;

  // Edge finding only on the second stage of each synchroniser
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sclk_s <= 2'h0;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], LINK.sclk};
      cs_s <= {cs_s[0], LINK.cs_n};
      mosi_s <= {mosi_s[0], LINK.mosi};
      sclk_prev_q <= sclk_s[1];
      cs_prev_q <= cs_s[1];
    end
  end

  wire cs_act = ~cs_s[1];
  wire cs_start = cs_act & cs_prev_q;
  wire sck_rise = sclk_s[1] & ~sclk_prev_q;
  wire sck_fall = ~sclk_s[1] & sclk_prev_q;
  wire word_fire = cs_act & sck_rise & (bit_q == `WSP_WORD_LAST);
  wire [15:0] word = {shift_q[14:0], mosi_s[1]};
  wire [3:0] wreg = word[15:12];
  wire reg_wr = word_fire & ~route_q;
  wire int_wr = word_fire & route_q;
  wire idle_end = ~cs_act & (idle_q == 11'(`WSP_ROUTE_IDLE_CYC - 1));
  wire bc_stat = (bc_q == `WSP_BC_STATUS);
  wire pa_busy = (pst_q != P_IDLE);
  wire [15:0] status_word = {13'h0000, route_q, pa_busy, empty_q};
  wire play_tick = (tdiv_q == 16'(PLAY_TICK_CYCLES - 1));

  // Receive shifter; a frame cut short is dropped
  always_ff @(posedge CLK) begin
    if (RESET || !cs_act) begin
      bit_q <= 4'h0;
      shift_q <= 16'h0000;
    end else if (sck_rise) begin
      shift_q <= word;
      bit_q <= bit_q + 4'h1;
    end
  end

  // Status goes out MSB first, next bit after each falling clock
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tx_q <= 16'h0000;
    end else if (cs_start) begin
      tx_q <= bc_stat ? status_word : 16'h0000;
    end else if (cs_act && sck_fall) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end
  assign LINK.miso = tx_q[15];

  // Idle timer runs only between frames
  always_ff @(posedge CLK) begin
    if (RESET || cs_act) begin
      idle_q <= 11'h000;
    end else if (idle_q != 11'(`WSP_ROUTE_IDLE_CYC)) begin
      idle_q <= idle_q + 11'h001;
    end
  end

  // Main register map
  always_ff @(posedge CLK) begin
    if (RESET) begin
      route_q <= 1'b0;
      mode_q <= 2'h0;
      bc_q <= 5'h00;
      oe_q <= 1'b0;
    end else begin
      if (reg_wr && wreg == `WSP_REG_RAM) begin
        mode_q <= word[1:0];
        route_q <= word[`WSP_ROUTE_BIT];
      end else if (idle_end) begin
        route_q <= 1'b0;
      end
      if (reg_wr && wreg == `WSP_REG_BCAST) begin
        bc_q <= word[`WSP_BC_HI:`WSP_BC_LO];
      end
      if (reg_wr && wreg == `WSP_REG_OUTPUT) begin
        oe_q <= word[`WSP_OE_BIT];
      end
    end
  end

  // Command interpreter; idle timeout drops any half-done command
  always_ff @(posedge CLK) begin
    if (RESET || idle_end) begin
      ist_q <= I_CMD;
      icnt_q <= 4'h0;
      burst_q <= 1'b0;
      wptr_q <= 10'h000;
    end else if (int_wr) begin
      unique case (ist_q)
        I_CMD: begin
          icnt_q <= 4'h0;
          if (word == `WSP_CMD_SYNTH_WR || word == `WSP_CMD_BURST_WR) begin
            burst_q <= (word == `WSP_CMD_BURST_WR);
            ist_q <= I_ADDR;
          end else if (word == `WSP_CMD_SEQ) begin
            ist_q <= I_SEQ;
          end else if (word == `WSP_CMD_RANGE) begin
            ist_q <= I_RANGE;
          end
        end
        I_ADDR: begin
          wptr_q <= word[9:0];
          ist_q <= I_DATA;
        end
        I_DATA: begin
          wptr_q <= wptr_q + 10'h001;
          icnt_q <= icnt_q + 4'h1;
          // Synthesis write carries one three-word block; burst runs to timeout
          if (!burst_q && icnt_q == `WSP_SYNTH_LAST) begin
            ist_q <= I_CMD;
          end
        end
        I_SEQ: begin
          icnt_q <= icnt_q + 4'h1;
          if (icnt_q == `WSP_SEQ_LAST) begin
            ist_q <= I_CMD;
          end
        end
        I_RANGE: begin
          ist_q <= I_CMD;
        end
      endcase
    end
  end

  // Play range must outlive the route timeout, so only reset clears it
  always_ff @(posedge CLK) begin
    if (RESET) begin
      start_q <= 4'h0;
      end_q <= 4'h0;
    end else if (int_wr && ist_q == I_RANGE) begin
      start_q <= clamp_entry(word[3:0]);
      end_q <= clamp_entry(word[7:4]);
    end
  end

  // Wave and slice storage
  always_ff @(posedge CLK) begin
    if (int_wr && ist_q == I_DATA) begin
      ram[wptr_q] <= word;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < 15; i++) begin
        seq_q[i] <= 10'h000;
      end
    end else if (int_wr && ist_q == I_SEQ) begin
      seq_q[icnt_q] <= word[9:0];
    end
  end

  // Block fetch: first slice, last slice, repeat count
  wire [9:0] base = seq_q[idx_q];
  wire [15:0] blk_cnt = ram[base + 10'h002];
  wire last_rep = (rep_q == 16'h0001);
  wire last_entry = (idx_q >= end_q);
  wire go = oe_q & ~oe_prev_q & (mode_q == `WSP_MODE_RAM_SYNTH);

  always_ff @(posedge CLK) begin
    if (RESET || pst_q != P_RUN) begin
      tdiv_q <= 16'h0000;
    end else begin
      tdiv_q <= play_tick ? 16'h0000 : tdiv_q + 16'h0001;
    end
  end

  // Playback walk
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pst_q <= P_IDLE;
      oe_prev_q <= 1'b0;
      idx_q <= 4'h0;
      sl_start_q <= 10'h000;
      sl_end_q <= 10'h000;
      pa_q <= 10'h000;
      rep_q <= 16'h0000;
      empty_q <= 1'b1;
    end else begin
      oe_prev_q <= oe_q;
      if (!oe_q) begin
        pst_q <= P_IDLE;
        empty_q <= 1'b1;
      end else if (go) begin
        idx_q <= start_q;
        empty_q <= 1'b0;
        pst_q <= P_FETCH;
      end else begin
        unique case (pst_q)
          P_IDLE: begin
          end
          P_FETCH: begin
            sl_start_q <= ram[base][9:0];
            sl_end_q <= ram[base + 10'h001][9:0];
            pa_q <= ram[base][9:0];
            rep_q <= (blk_cnt == 16'h0000) ? 16'h0001 : blk_cnt;
            pst_q <= P_RUN;
          end
          P_RUN: begin
            if (play_tick) begin
              if (pa_q != sl_end_q) begin
                pa_q <= pa_q + 10'h001;
              end else if (!last_rep) begin
                rep_q <= rep_q - 16'h0001;
                pa_q <= sl_start_q;
              end else if (!last_entry) begin
                idx_q <= idx_q + 4'h1;
                pst_q <= P_FETCH;
              end else begin
                empty_q <= 1'b1;
                pst_q <= P_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Outputs held in flops for clean timing
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PLAY_ACTIVE <= 1'b0;
      PLAY_SLICE_ADDR <= 10'h000;
      PLAY_EMPTY <= 1'b1;
    end else begin
      PLAY_ACTIVE <= (pst_q == P_RUN);
      PLAY_SLICE_ADDR <= pa_q;
      PLAY_EMPTY <= empty_q;
    end
  end
endmodule
`default_nettype wire

// file: wsp_host.sv
// Purpose: Host end: APB-commanded serial master for the player
// Assumes: Software spaces words and waits out the route timeout
// Notes: Link clock made by divider, mode 0, MSB first
`include "wsp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module wsp_host #(
  parameter int SCLK_HALF = 6
) (
  input wire logic CLK,
  input wire logic RESET,
  wsp_link_if.host LINK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  import wsp_pkg::*;

  logic [1:0] miso_s;
  wsp_hst_t hst_q;
  logic [7:0] div_q;
  logic sclk_q, cs_n_q, mosi_q;
  logic [3:0] bit_q;
  wsp_word_t txsh_q, rxsh_q, rx_q;
  logic [10:0] idle_q;

  wire acc = PSEL & PENABLE;
  wire hit_tx = (PADDR == `WSP_APB_TX);
  wire hit_rx = (PADDR == `WSP_APB_RX);
  wire hit_st = (PADDR == `WSP_APB_STAT);
  wire busy = (hst_q != H_IDLE);
  // Status shows when the far end has surely fallen back to its registers
  wire idle_long = (idle_q > 11'(`WSP_ROUTE_IDLE_CYC));
  wire [31:0] rd_mux = hit_rx ? {16'h0000, rx_q} :
                       hit_st ? {30'h0000_0000, idle_long, busy} : 32'h0000_0000;
  wire start = acc & PREADY & PWRITE & hit_tx & ~busy;
  wire tick = (div_q == 8'(SCLK_HALF - 1));

  // One wait state on every access
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (acc && !PREADY) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
      PSLVERR <= ~(hit_tx | hit_rx | hit_st);
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      miso_s <= 2'h0;
    end else begin
      miso_s <= {miso_s[0], LINK.miso};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || hst_q == H_IDLE || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Link clock idles low; read data taken just before each falling edge
  always_ff @(posedge CLK) begin
    if (RESET) begin
      hst_q <= H_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      bit_q <= 4'h0;
      txsh_q <= 16'h0000;
      rxsh_q <= 16'h0000;
      rx_q <= 16'h0000;
    end else begin
      unique case (hst_q)
        H_IDLE: begin
          if (start) begin
            txsh_q <= PWDATA[15:0];
            mosi_q <= PWDATA[15];
            cs_n_q <= 1'b0;
            bit_q <= 4'h0;
            hst_q <= H_XFER;
          end
        end
        H_XFER: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              rxsh_q <= {rxsh_q[14:0], miso_s[1]};
              if (bit_q == `WSP_WORD_LAST) begin
                hst_q <= H_END;
              end else begin
                bit_q <= bit_q + 4'h1;
                mosi_q <= txsh_q[14];
                txsh_q <= {txsh_q[14:0], 1'b0};
              end
            end
          end
        end
        H_END: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            rx_q <= rxsh_q;
            hst_q <= H_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || !cs_n_q) begin
      idle_q <= 11'h000;
    end else if (!idle_long) begin
      idle_q <= idle_q + 11'h001;
    end
  end

  assign LINK.sclk = sclk_q;
  assign LINK.cs_n = cs_n_q;
  assign LINK.mosi = mosi_q;
endmodule
`default_nettype wire

// file: wsp_link_chk.sv
// Purpose: Link framing and playback checks
// Assumes: Both ends run on CLK
// Notes: Half periods counted by helper flops
`timescale 1ns/100ps
`default_nettype none
module wsp_link_chk #(
  parameter int SCLK_HALF = 6
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic PLAY_ACTIVE,
  input wire logic PLAY_EMPTY
);
  logic sclk_q;
  logic [7:0] half_q;
  logic [4:0] rise_q;
  wire logic sclk_chg = sclk != sclk_q;
  wire logic sclk_up = sclk && !sclk_q && !cs_n;
  always_ff @(posedge CLK) begin
    sclk_q <= sclk;
    half_q <= sclk_chg ? 8'h00 : half_q + 8'h01;
    rise_q <= cs_n ? 5'h00 : rise_q + {4'h0, sclk_up};
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_open;
    $fell(cs_n);
  endsequence
  sequence s_first;
    ##[SCLK_HALF:SCLK_HALF] $rose(sclk);
  endsequence
  property p_rst_idle;
    $fell(RESET) |-> cs_n && !sclk && PLAY_EMPTY;
  endproperty
  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  property p_half;
    sclk_q && !sclk && !cs_n |-> half_q == 8'(SCLK_HALF - 1);
  endproperty
  property p_mosi_hold;
    sclk && sclk_q |-> $stable(mosi);
  endproperty
  property p_first_rise;
    s_open |-> s_first;
  endproperty
  property p_sixteen;
    $rose(cs_n) |-> rise_q == 5'h10;
  endproperty
  property p_start;
    $fell(PLAY_EMPTY) |-> ##[0:4] PLAY_ACTIVE;
  endproperty
  property p_busy_not_empty;
    PLAY_ACTIVE |-> !PLAY_EMPTY;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moves outside frame");
  a_half: assert property (p_half) else $error("sclk half period off");
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");
  a_first_rise: assert property (p_first_rise) else $error("first sclk rise late");
  a_sixteen: assert property (p_sixteen) else $error("frame not sixteen bits");
  a_start: assert property (p_start) else $error("playback did not start");
  a_busy_not_empty: assert property (p_busy_not_empty) else $error("empty while playing");
endmodule
`default_nettype wire

// file: waveform_sequence_player_tb.sv
// Purpose: End-to-end bench, APB host to player
// Assumes: Tick of 64 cycles per slice word
// Notes: Played cycles counted per address
`include "wsp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module waveform_sequence_player_tb;
  import wsp_pkg::*;
  localparam int TICK = 64;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic act;
  logic empty;
  logic e;
  wsp_addr_t slice;
  int miscompares = 0;
  int num_checks = 0;
  int n_act, n_102, n_201;
  logic [15:0] mon;
  logic [31:0] q;
  wsp_link_if link ();
  wsp_host #(.SCLK_HALF(6)) wsp_host_inst (.CLK(clk), .RESET(reset), .LINK(link.host),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  wsp_dev #(.PLAY_TICK_CYCLES(TICK)) wsp_dev_inst (.CLK(clk), .RESET(reset), .LINK(link.dev),
    .PLAY_ACTIVE(act), .PLAY_SLICE_ADDR(slice), .PLAY_EMPTY(empty));
  wsp_link_chk #(.SCLK_HALF(6)) wsp_link_chk_inst (.CLK(clk), .RESET(reset),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .PLAY_ACTIVE(act),
    .PLAY_EMPTY(empty));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (act === 1'b1) begin
      n_act++;
      n_102 += (slice === 10'h102);
      n_201 += (slice === 10'h201);
    end
  end
  // Bits gathered as the player sees them
  always @(posedge link.sclk) begin
    if (!link.cs_n) begin
      mon = {mon[14:0], link.mosi};
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stat_wait(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `WSP_APB_STAT, 32'h0000_0000);
      n++;
    end while (q[b] !== v && n < 2000);
  endtask
  task automatic send(input logic [15:0] w);
    stat_wait(0, 1'b0);
    apb(1'b1, `WSP_APB_TX, {16'h0000, w});
    stat_wait(0, 1'b0);
    check("wire word", {16'h0000, mon}, {16'h0000, w});
  endtask
  // Stray words after the timeout must land in the register map
  task automatic play(input logic [15:0] rng, input int e_act, input int e_102, input int e_201);
    int n;
    send(16'h8007);
    send(`WSP_CMD_RANGE);
    send(rng);
    stat_wait(1, 1'b1);
    check("idle flag", {31'h0000_0000, q[1]}, 32'h0000_0001);
    send(`WSP_CMD_RANGE);
    send(16'h0011);
    send(16'h9628);
    n_act = 0;
    n_102 = 0;
    n_201 = 0;
    send(16'h5010);
    n = 0;
    do begin
      send(16'h0000);
      apb(1'b0, `WSP_APB_RX, 32'h0000_0000);
      if (n == 0) check("status playing", q, 32'h0000_0002);
      n++;
    end while (q[0] !== 1'b1 && n < 60);
    check("status done", q, 32'h0000_0001);
    check("played cycles", n_act, e_act);
    check("last slice of wave 0", n_102, e_102);
    check("last slice of wave 3", n_201, e_201);
    send(16'h5000);
    check("empty after stop", {31'h0000_0000, empty}, 32'h0000_0001);
  endtask
  // Clearing output enable mid-sequence must end playback at once
  task automatic stop_early();
    send(16'h5010);
    check("empty while playing", {31'h0000_0000, empty}, 32'h0000_0000);
    send(16'h5000);
    check("empty after early stop", {31'h0000_0000, empty}, 32'h0000_0001);
    send(16'h0000);
    apb(1'b0, `WSP_APB_RX, 32'h0000_0000);
    check("status after early stop", q, 32'h0000_0001);
  endtask
  task automatic test_done();
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check("unmapped error", {31'h0000_0000, e}, 32'h0000_0001);
    send(16'h8007);
    send(`WSP_CMD_SYNTH_WR);
    send(16'h0000);
    send(16'h0100);
    send(16'h0102);
    send(16'h0002);
    send(`WSP_CMD_SEQ);
    send(16'hFC00);
    send(16'h0003);
    for (int i = 2; i < 15; i++) begin
      send(16'h03F0);
    end
    send(`WSP_CMD_BURST_WR);
    send(16'h0003);
    send(16'h0200);
    send(16'h0201);
    send(16'h0000);
    stat_wait(1, 1'b1);
    apb(1'b0, `WSP_APB_RX, 32'h0000_0000);
    check("status unselected", q, 32'h0000_0000);
    play(16'h0010, 8 * TICK, 2 * TICK, TICK);
    play(16'h0011, 2 * TICK, 0, TICK);
    send(16'h8007);
    send(`WSP_CMD_SEQ);
    for (int i = 0; i < 15; i++) begin
      send(16'h0003);
    end
    stat_wait(1, 1'b1);
    play(16'h00E0, 30 * TICK, 0, 15 * TICK);
    stop_early();
    test_done();
  end
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
